// >>> hdl/usbds_core.sv
// Purpose: usb device global state, frame number capture and ram/dpram byte dma
// Assumes: ahb-lite slave, zero wait states, single 32-bit transfers
// Notes: the processor is held by cpu_stall for the whole dma operation
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - eight endpoint reset bits, bit n resets endpoint n, hardware clears.
// - endpoint reset rewinds buffer pointers and zeroes the data toggle.
// - resume-active flag stands while resume is driven, about 13 ms.
// - remote wake-up needs the enable bit, global state bit 2.
// - configured flag bit 1 cleared by bus reset, otherwise software-owned.
// - bus reset clears function address and addressed flag.
// - frame-end bit 12 set at sof end of packet, cleared at next sof.
// - frame-number error bit 11 follows corruption of last frame number.
// - hardware captures 11-bit frame number, read while frame-end set.
// - dma copies bytes between system ram and endpoint dual-port buffer.
// - usb registers are unreachable while the usb module is disabled.
// - a dma of n bytes finishes within n+1 clock cycles.
// - dma stalls the processor until the transfer ends.
// - the usb function interface logic moves the bytes, not the processor.
// - dma register: endpoint 6..4, error 2, direction 1, run 0.
// - software sets run to launch, hardware clears it at completion.
// - direction 0 endpoint to ram, direction 1 ram to endpoint.
// - endpoint select picks endpoint 0 to 4 for the next dma; 5 to 7 fail at launch.
// - bad address or count at launch sets error and raises interrupt.
module usbds_core #(
   parameter int RESUME_LEN = usbds_pkg::RESUME_CYCLES
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // usb module and serial engine
   input wire logic usb_enable,
   input wire logic bus_reset,
   input wire logic wakeup_req,
   input wire usbds_pkg::usbds_sof_type sof,
   output logic resume_drive,
   output logic [7:0] ep_ptr_reset,
   output logic [7:0] ep_toggle_clear,
   output logic [6:0] function_addr,
   // dma setup and processor hold
   input wire logic [13:0] dma_base_addr,
   input wire logic [6:0] dma_byte_count,
   output logic [13:0] dma_next_addr,
   output logic dma_addr_load,
   output logic cpu_stall,
   output logic dma_irq,
   // system ram port
   input wire logic [7:0] ram_rdata,
   output usbds_pkg::usbds_mem_type ram_req,
   // dual-port buffer port
   input wire logic [7:0] dp_rdata,
   output logic [2:0] dp_ep,
   output usbds_pkg::usbds_mem_type dp_req
);
   import usbds_pkg::*;

   logic wr_pend;
   logic [9:0] wr_idx;
   logic [7:0] wb;
   logic wr_rst, wr_gs, wr_fa, wr_dma;
   logic [7:0] rd_val;
   logic [9:0] a_idx;
   logic [7:0] ep_bits;
   logic [7:0] ep_strobe;
   logic remote_wakeup_enable, configured_flag, addressed_flag;
   logic resume_signalling_active;
   logic [18:0] resume_cnt;
   logic frame_end_seen, frame_num_error;
   logic [10:0] frame_num_value;
   logic [2:0] dma_endpoint_select;
   logic dma_error_flag, dma_direction, dma_run;
   usbds_dma_state_type state;
   logic [7:0] idx;
   logic [6:0] xfer_len;
   logic [13:0] xfer_base;
   logic launch, launch_bad;
   logic [7:0] ep_size;
   logic [14:0] dma_end;

   // ---------------- ahb-lite slave ----------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign a_idx = haddr[11:2];

   always_comb begin
      case (a_idx)
         IDX_EP_RESET: rd_val = ep_bits;
         IDX_GLOBAL: rd_val = {4'h0, resume_signalling_active, remote_wakeup_enable,
            configured_flag, addressed_flag};
         IDX_FADDR: rd_val = {1'b0, function_addr};
         IDX_FN_LOW: rd_val = frame_num_value[7:0];
         IDX_FN_HIGH: rd_val = {3'h0, frame_end_seen, frame_num_error,
            frame_num_value[10:8]};
         IDX_DMA_CS: rd_val = {1'b0, dma_endpoint_select, 1'b0, dma_error_flag,
            dma_direction, dma_run};
         default: rd_val = 8'h00;
      endcase
   end

   // address phase captured; read data launched from a flop for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= 10'h000;
         hrdata <= 32'h00000000;
      end else if (hready) begin
         wr_pend <= hsel && htrans[1] && hwrite && usb_enable;
         wr_idx <= a_idx;
         if (hsel && htrans[1] && !hwrite && usb_enable) begin
            hrdata <= {24'h000000, rd_val};
         end else begin
            hrdata <= 32'h00000000;
         end
      end
   end

   assign wb = hwdata[7:0];
   assign wr_rst = wr_pend && (wr_idx == IDX_EP_RESET);
   assign wr_gs = wr_pend && (wr_idx == IDX_GLOBAL);
   assign wr_fa = wr_pend && (wr_idx == IDX_FADDR);
   assign wr_dma = wr_pend && (wr_idx == IDX_DMA_CS);

   // ---------------- endpoint reset ----------------
   usbds_ep_reset u_ep_reset (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_en(wr_rst),
      .wr_data(wb),
      .reset_bits(ep_bits),
      .reset_strobe(ep_strobe)
   );
   assign ep_ptr_reset = ep_strobe;
   assign ep_toggle_clear = ep_strobe;

   // ---------------- global state and address ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         remote_wakeup_enable <= 1'b0;
         configured_flag <= 1'b0;
         addressed_flag <= 1'b0;
         function_addr <= 7'h00;
      end else begin
         if (wr_gs) begin
            remote_wakeup_enable <= wb[GS_WAKE_EN];
            configured_flag <= wb[GS_CONFIGURED];
            addressed_flag <= wb[GS_ADDRESSED];
         end
         if (wr_fa) begin
            function_addr <= wb[6:0];
         end
         // bus reset is a hardware clear and overrides a coincident write
         if (bus_reset) begin
            configured_flag <= 1'b0;
            addressed_flag <= 1'b0;
            function_addr <= 7'h00;
         end
      end
   end

   // ---------------- remote wake-up resume ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resume_signalling_active <= 1'b0;
         resume_cnt <= 19'h00000;
      end else if (resume_signalling_active) begin
         if (resume_cnt == 19'(RESUME_LEN - 1)) begin
            resume_signalling_active <= 1'b0;
         end else begin
            resume_cnt <= resume_cnt + 19'h00001;
         end
      end else if (wakeup_req && remote_wakeup_enable) begin
         resume_signalling_active <= 1'b1;
         resume_cnt <= 19'h00000;
      end
   end
   assign resume_drive = resume_signalling_active;

   // ---------------- frame number ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_end_seen <= 1'b0;
         frame_num_error <= 1'b0;
         frame_num_value <= 11'h000;
      end else begin
         // end of packet wins when it meets the next start in one cycle
         if (sof.eop) begin
            frame_end_seen <= 1'b1;
            frame_num_error <= !sof.crc_ok;
            if (sof.crc_ok) begin
               frame_num_value <= sof.num;
            end
         end else if (sof.start) begin
            frame_end_seen <= 1'b0;
         end
      end
   end

   // ---------------- dma ----------------
   always_comb begin
      case (dma_endpoint_select)
         3'h0: ep_size = EP0_SIZE;
         3'h1, 3'h2, 3'h3: ep_size = EP_BULK_SIZE;
         default: ep_size = EP_SMALL_SIZE;
      endcase
   end
   assign dma_end = {1'b0, dma_base_addr} + {8'h00, dma_byte_count} - 15'h0001;
   assign launch = wr_dma && wb[DMA_RUN_POS] && (state == DMA_IDLE);
   // window checked on the registers as they stand before the launch write
   assign launch_bad = (dma_byte_count == 7'h00) || (dma_endpoint_select > EP_LAST_DMA)
      || ({1'b0, dma_byte_count} > ep_size) || ({1'b0, dma_base_addr} < DMA_RAM_LO)
      || (dma_end > DMA_RAM_HI);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_endpoint_select <= 3'h0;
         dma_direction <= 1'b0;
         dma_error_flag <= 1'b0;
      end else if (wr_dma && state == DMA_IDLE) begin
         dma_endpoint_select <= wb[DMA_EPS_LSB +: 3];
         dma_direction <= wb[DMA_DIR_POS];
         if (launch) begin
            dma_error_flag <= launch_bad;
         end else begin
            dma_error_flag <= wb[DMA_ERR_POS];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= DMA_IDLE;
         dma_run <= 1'b0;
         idx <= 8'h00;
         xfer_len <= 7'h00;
         xfer_base <= RST_ADDR;
         dma_next_addr <= RST_ADDR;
         dma_addr_load <= 1'b0;
      end else begin
         dma_addr_load <= 1'b0;
         case (state)
            DMA_IDLE: begin
               if (launch && !launch_bad) begin
                  state <= DMA_XFER;
                  dma_run <= 1'b1;
                  idx <= 8'h00;
                  xfer_len <= dma_byte_count;
                  xfer_base <= dma_base_addr;
               end
            end
            DMA_XFER: begin
               if (idx == {1'b0, xfer_len}) begin
                  state <= DMA_IDLE;
                  dma_run <= 1'b0;
                  dma_next_addr <= xfer_base + {7'h00, xfer_len};
                  dma_addr_load <= 1'b1;
               end else begin
                  idx <= idx + 8'h01;
               end
            end
            default: begin
               state <= DMA_IDLE;
               dma_run <= 1'b0;
            end
         endcase
      end
   end

   assign cpu_stall = dma_run;
   assign dma_irq = dma_error_flag;
   assign dp_ep = dma_endpoint_select;

   // byte i is read at step i and written at step i+1; reads have one cycle latency
   always_comb begin
      ram_req = '0;
      dp_req = '0;
      if (state == DMA_XFER) begin
         if (dma_direction) begin
            ram_req.re = idx < {1'b0, xfer_len};
            ram_req.addr = xfer_base + {6'h00, idx};
            dp_req.we = idx != 8'h00;
            dp_req.addr = {6'h00, idx - 8'h01};
            dp_req.wdata = ram_rdata;
         end else begin
            dp_req.re = idx < {1'b0, xfer_len};
            dp_req.addr = {6'h00, idx};
            ram_req.we = idx != 8'h00;
            ram_req.addr = xfer_base + {6'h00, idx} - 14'h0001;
            ram_req.wdata = dp_rdata;
         end
      end
   end

   // ---------------- checks ----------------
   logic [7:0] stall_cnt;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stall_cnt <= 8'h00;
      end else if (cpu_stall) begin
         stall_cnt <= stall_cnt + 8'h01;
      end else begin
         stall_cnt <= 8'h00;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_ep_reset_done: assert property ((ep_bits != 8'h00 && !wr_rst) |-> ##[1:5]
      (ep_bits == 8'h00 || wr_rst))
      else $error("endpoint reset bit did not self-clear");
   a_ep_strobe_fall: assert property ((|ep_strobe) |-> (ep_strobe & ~$past(ep_bits)) == 8'h00
      && (ep_bits & ep_strobe) == 8'h00)
      else $error("endpoint strobe while its reset bit still set");
   a_bus_reset_addr: assert property (bus_reset |=> (function_addr == 7'h00)
      && !addressed_flag)
      else $error("bus reset left address state");
   a_bus_reset_cfg: assert property (bus_reset |=> !configured_flag)
      else $error("bus reset left configured flag set");
   a_resume_needs_en: assert property ($rose(resume_signalling_active) |->
      $past(remote_wakeup_enable))
      else $error("resume started without wake-up enable");
   a_resume_bound: assert property (resume_signalling_active |->
      resume_cnt < 19'(RESUME_LEN))
      else $error("resume signalling too long");
   a_frame_end_set: assert property (sof.eop |=> frame_end_seen
      && frame_num_error == !$past(sof.crc_ok))
      else $error("frame end or error not captured");
   a_frame_start_clr: assert property ((sof.start && !sof.eop) |=> !frame_end_seen)
      else $error("frame end not cleared at sof");
   a_dma_cycles: assert property ($fell(cpu_stall) |->
      $past(stall_cnt) == {1'b0, $past(xfer_len)})
      else $error("dma took other than n+1 cycles");
   a_dma_bad_launch: assert property ((launch && launch_bad) |=> dma_error_flag
      && !dma_run && dma_irq)
      else $error("bad dma launch not flagged");
   a_usb_disabled: assert property ((hready && !usb_enable) |=> hrdata == 32'h00000000
      && !wr_pend)
      else $error("register reached while usb disabled");
endmodule
`default_nettype wire

// >>> hdl/usbds_pkg.sv
// Purpose: shared constants and carrier types for the usb device state and dma block
// Assumes: 32-bit ahb-lite register bus, 20 MHz hclk
// Notes: register byte address is four times the register index
package usbds_pkg;
   // register indices (byte address = index * 4)
   localparam logic [9:0] IDX_EP_RESET = 10'h0E5;
   localparam logic [9:0] IDX_GLOBAL = 10'h0E6;
   localparam logic [9:0] IDX_FADDR = 10'h0E7;
   localparam logic [9:0] IDX_FN_LOW = 10'h0E8;
   localparam logic [9:0] IDX_FN_HIGH = 10'h0E9;
   localparam logic [9:0] IDX_DMA_CS = 10'h0EA;
   // field positions
   localparam int GS_ADDRESSED = 0;
   localparam int GS_CONFIGURED = 1;
   localparam int GS_WAKE_EN = 2;
   localparam int GS_RESUME_ON = 3;
   localparam int FN_ERR_POS = 11;
   localparam int FN_END_POS = 12;
   localparam int DMA_RUN_POS = 0;
   localparam int DMA_DIR_POS = 1;
   localparam int DMA_ERR_POS = 2;
   localparam int DMA_EPS_LSB = 4;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [13:0] RST_ADDR = 14'h0000;
   // timing
   localparam int CLK_HZ = 20000000;
   localparam int RESUME_TIME_MS = 13;
   localparam int RESUME_CYCLES = RESUME_TIME_MS * (CLK_HZ / 1000);
   localparam int EP_RST_CYCLES = 4;
   // dma window and endpoint sizes
   localparam logic [14:0] DMA_RAM_LO = 15'h0100;
   localparam logic [14:0] DMA_RAM_HI = 15'h10FF;
   localparam logic [7:0] EP0_SIZE = 8'h40;
   localparam logic [7:0] EP_BULK_SIZE = 8'h80;
   localparam logic [7:0] EP_SMALL_SIZE = 8'h08;
   localparam logic [2:0] EP_LAST_DMA = 3'h4;

   typedef enum logic [1:0] {
      DMA_IDLE = 2'b00,
      DMA_XFER = 2'b01
   } usbds_dma_state_type;

   // start-of-frame events from the serial engine
   typedef struct packed {
      logic start;
      logic eop;
      logic crc_ok;
      logic [10:0] num;
   } usbds_sof_type;

   // one byte-wide memory request
   typedef struct packed {
      logic re;
      logic we;
      logic [13:0] addr;
      logic [7:0] wdata;
   } usbds_mem_type;
endpackage

// >>> hdl/usbds_ep_reset.sv
// Purpose: per-endpoint reset request bits that clear themselves when done
// Assumes: software write has priority over the hardware clear
// Notes: one strobe per endpoint when its reset completes
`timescale 1ns/1ps
`default_nettype none
module usbds_ep_reset
   import usbds_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // software access
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // state and strobes
   output logic [7:0] reset_bits,
   output logic [7:0] reset_strobe
);
   genvar n;
   generate
      for (n = 0; n < 8; n = n + 1) begin : g_ep
         logic [2:0] cnt;
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               reset_bits[n] <= 1'b0;
               reset_strobe[n] <= 1'b0;
               cnt <= 3'h0;
            end else if (wr_en) begin
               // a write wins over completion so a fresh request is never lost
               reset_bits[n] <= wr_data[n];
               reset_strobe[n] <= 1'b0;
               cnt <= 3'h0;
            end else if (reset_bits[n]) begin
               if (cnt == 3'(EP_RST_CYCLES - 1)) begin
                  reset_bits[n] <= 1'b0;
                  reset_strobe[n] <= 1'b1;
               end else begin
                  cnt <= cnt + 3'h1;
               end
            end else begin
               reset_strobe[n] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// >>> tb/usbds_mem_model.sv
// Purpose: byte memory standing for system ram or the endpoint dual-port buffer
// Assumes: read data comes one cycle after a read request
// Notes: between reads the data lines toggle, so a stale byte is never trusted
`timescale 1ns/1ps
`default_nettype none
module usbds_mem_model
   import usbds_pkg::*;
(
   // clock
   input wire logic hclk,
   // request side
   input wire logic [2:0] bank,
   input wire usbds_pkg::usbds_mem_type req,
   output var logic [7:0] rdata = 8'h5A
);
   logic [7:0] mem [0:16383];
   logic [13:0] idx;
   // each endpoint gets its own page so a wrong endpoint select shows up
   assign idx = req.addr ^ {bank, 11'h000};
   always @(posedge hclk) begin
      if (req.we) begin
         mem[idx] <= req.wdata;
      end
      if (req.re) begin
         rdata <= mem[idx];
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule
`default_nettype wire

// >>> tb/usb_device_state_and_buffer_dma_bench.sv
// Purpose: self-checking bench for the usb device state and dma block
// Assumes: zero wait-state slave, short resume length for simulation
// Notes: expectations come from small integer models kept here
`timescale 1ns/1ps
`default_nettype none
module usb_device_state_and_buffer_dma_bench;
   import usbds_pkg::*;
   localparam int RES_LEN = 20;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic usb_enable = 1'b1;
   logic bus_reset = 1'b0;
   logic wakeup_req = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [13:0] base = 14'h0100;
   logic [6:0] cnt = 7'h00;
   usbds_sof_type sof_in = '0;
   logic hready, hresp, resume_drive, dma_addr_load, cpu_stall, dma_irq;
   logic [31:0] hrdata;
   logic [7:0] ep_ptr_reset, ep_toggle_clear, ram_rdata, dp_rdata;
   logic [6:0] function_addr;
   logic [13:0] dma_next_addr;
   logic [2:0] dp_ep;
   usbds_mem_type ram_req, dp_req;
   int error_cnt = 0;
   int compares = 0;
   int stall_n = 0;
   int res_n = 0;
   int fn_v = 0;
   int fn_e = 0;
   int fn_r = 0;
   logic load_seen = 1'b0;
   logic [13:0] load_val = 14'h0000;
   logic [31:0] seed = 32'hA580C557;

   usbds_core #(.RESUME_LEN(RES_LEN)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .usb_enable(usb_enable), .bus_reset(bus_reset), .wakeup_req(wakeup_req), .sof(sof_in),
      .resume_drive(resume_drive), .ep_ptr_reset(ep_ptr_reset),
      .ep_toggle_clear(ep_toggle_clear), .function_addr(function_addr),
      .dma_base_addr(base), .dma_byte_count(cnt), .dma_next_addr(dma_next_addr),
      .dma_addr_load(dma_addr_load), .cpu_stall(cpu_stall), .dma_irq(dma_irq),
      .ram_rdata(ram_rdata), .ram_req(ram_req), .dp_rdata(dp_rdata), .dp_ep(dp_ep),
      .dp_req(dp_req));
   usbds_mem_model ram_m (.hclk(hclk), .bank(3'h0), .req(ram_req), .rdata(ram_rdata));
   usbds_mem_model dp_m (.hclk(hclk), .bank(dp_ep), .req(dp_req), .rdata(dp_rdata));

   always #25 hclk = ~hclk;

   always @(posedge hclk) begin
      if (cpu_stall === 1'b1) stall_n <= stall_n + 1;
      if (resume_drive === 1'b1) res_n <= res_n + 1;
      if (dma_addr_load === 1'b1) begin
         load_seen <= 1'b1;
         load_val <= dma_next_addr;
      end
   end

   task conclude();
      if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic bound(input int k, input int lim, input string nm);
      if (k >= lim) begin
         error_cnt++;
         $display("unexpected %s expected done seen timeout", nm);
         conclude();
      end
   endtask

   function automatic logic [31:0] next_rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic ahb(input logic w, input logic [9:0] idx, input logic [7:0] wd,
         output logic [31:0] rd);
      int n;
      n = 0;
      haddr <= {20'h00000, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      hsel <= 1'b1;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      htrans <= 2'b00;
      hwdata <= {24'h000000, wd};
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 40);
      rd = hrdata;
      bound(n, 40, "bus answer");
      chk("response", 32'h0, {31'h0, hresp});
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] x;
      ahb(1'b1, idx, d, x);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input string nm);
      logic [31:0] x;
      ahb(1'b0, idx, 8'h00, x);
      chk(nm, exp, x);
   endtask

   // frame events, then both frame registers against the integer model
   task automatic sof_ev(input logic s, input logic e, input logic c, input logic [10:0] num);
      sof_in <= {s, e, c, num};
      @(posedge hclk);
      sof_in <= '0;
      if (e) begin
         fn_e = 1;
         fn_r = c ? 0 : 1;
         if (c) fn_v = int'(num);
      end else if (s) begin
         fn_e = 0;
      end
      rd(IDX_FN_LOW, 32'(fn_v & 255), "frame low");
      rd(IDX_FN_HIGH, 32'((fn_e << 4) | (fn_r << 3) | (fn_v >> 8)), "frame high");
   endtask

   task automatic dma_go(input logic [2:0] e, input logic d, input logic [13:0] b,
         input logic [6:0] n);
      logic [31:0] r;
      logic [13:0] dpi;
      int k;
      base <= b;
      cnt <= n;
      for (k = 0; k < int'(n); k++) begin
         r = next_rnd();
         dpi = 14'(k) ^ {e, 11'h000};
         if (d) ram_m.mem[b + 14'(k)] = r[7:0];
         else dp_m.mem[dpi] = r[7:0];
      end
      wr(IDX_DMA_CS, {1'b0, e, 4'h0});
      stall_n = 0;
      load_seen = 1'b0;
      wr(IDX_DMA_CS, {1'b0, e, 2'b00, d, 1'b1});
      for (k = 0; k < 300 && load_seen !== 1'b1; k++) @(posedge hclk);
      bound(k, 300, "dma end");
      chk("stall cycles", 32'(n) + 32'h1, 32'(stall_n));
      chk("next address", {18'h0, b + 14'(n)}, {18'h0, load_val});
      for (k = 0; k < int'(n); k++) begin
         dpi = 14'(k) ^ {e, 11'h000};
         chk("moved byte", {24'h0, ram_m.mem[b + 14'(k)]}, {24'h0, dp_m.mem[dpi]});
      end
      rd(IDX_DMA_CS, {25'h0, e, 2'b00, d, 1'b0}, "dma status");
   endtask

   initial begin
      repeat (100000) @(posedge hclk);
      bound(1, 1, "run length");
   end

   initial begin
      logic [31:0] r;
      logic [7:0] p;
      static logic [2:0] ee [6] = '{3'h1, 3'h5, 3'h7, 3'h0, 3'h1, 3'h4};
      static logic [13:0] eb [6] = '{14'h0100, 14'h0100, 14'h0100, 14'h00FF, 14'h10FF, 14'h0100};
      static logic [6:0] en [6] = '{7'h00, 7'h01, 7'h01, 7'h01, 7'h02, 7'h09};
      int n;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(IDX_EP_RESET + 10'(i), 32'h0, "reset value");
      wr(10'h0EB, 8'hFF);
      rd(10'h0EB, 32'h0, "unmapped read");
      wr(IDX_FADDR, 8'hD5);
      wr(IDX_GLOBAL, 8'h0F);
      rd(IDX_GLOBAL, 32'h07, "global state");
      rd(IDX_FADDR, 32'h55, "function address");
      chk("address pin", 32'h55, {25'h0, function_addr});
      usb_enable <= 1'b0;
      wr(IDX_FADDR, 8'h11);
      rd(IDX_FADDR, 32'h0, "disabled read");
      usb_enable <= 1'b1;
      rd(IDX_FADDR, 32'h55, "address kept");
      bus_reset <= 1'b1;
      @(posedge hclk);
      bus_reset <= 1'b0;
      rd(IDX_GLOBAL, 32'h04, "global after bus reset");
      rd(IDX_FADDR, 32'h0, "address after bus reset");
      chk("address pin", 32'h0, {25'h0, function_addr});
      // resume only with wake-up enabled, for the fixed length
      wakeup_req <= 1'b1;
      @(posedge hclk);
      wakeup_req <= 1'b0;
      rd(IDX_GLOBAL, 32'h0C, "resume flag");
      for (n = 0; n < 100 && resume_drive === 1'b1; n++) @(posedge hclk);
      bound(n, 100, "resume end");
      chk("resume cycles", 32'(RES_LEN), 32'(res_n));
      rd(IDX_GLOBAL, 32'h04, "resume flag off");
      wr(IDX_GLOBAL, 8'h00);
      res_n = 0;
      wakeup_req <= 1'b1;
      @(posedge hclk);
      wakeup_req <= 1'b0;
      repeat (30) @(posedge hclk);
      chk("resume disabled", 32'h0, 32'(res_n));
      // endpoint reset procedure, random endpoint mask
      r = next_rnd();
      p = r[7:0] | 8'h01;
      wr(IDX_EP_RESET, 8'h00);
      wr(IDX_EP_RESET, p);
      for (n = 0; n < 10 && ep_ptr_reset === 8'h00; n++) @(posedge hclk);
      chk("pointer reset", {24'h0, p}, {24'h0, ep_ptr_reset});
      chk("toggle clear", {24'h0, p}, {24'h0, ep_toggle_clear});
      // bits clear at the count's last edge, the strobe is seen one edge later
      chk("reset time", 32'(EP_RST_CYCLES + 1), 32'(n));
      rd(IDX_EP_RESET, 32'h0, "reset bits cleared");
      sof_ev(1'b1, 1'b0, 1'b1, 11'h000);
      sof_ev(1'b0, 1'b1, 1'b1, r[18:8]);
      sof_ev(1'b1, 1'b0, 1'b1, 11'h000);
      sof_ev(1'b0, 1'b1, 1'b0, ~r[18:8]);
      sof_ev(1'b0, 1'b1, 1'b1, r[29:19]);
      for (int e = 0; e < 5; e++) begin
         n = (e == 0) ? 64 : (e == 4) ? 8 : 127;
         dma_go(3'(e), e[0], 14'h0100 + 14'(e * 512), 7'(n));
      end
      dma_go(3'h4, 1'b0, 14'h10F8, 7'h08);
      for (int i = 0; i < 6; i++) begin
         base <= eb[i];
         cnt <= en[i];
         wr(IDX_DMA_CS, {1'b0, ee[i], 4'h0});
         stall_n = 0;
         wr(IDX_DMA_CS, {1'b0, ee[i], 4'h1});
         rd(IDX_DMA_CS, {25'h0, ee[i], 4'h4}, "dma error");
         chk("dma irq", 32'h1, {31'h0, dma_irq});
         chk("stall on error", 32'h0, 32'(stall_n));
         wr(IDX_DMA_CS, {1'b0, ee[i], 4'h0});
         rd(IDX_DMA_CS, {25'h0, ee[i], 4'h0}, "dma error cleared");
         chk("dma irq off", 32'h0, {31'h0, dma_irq});
      end
      conclude();
   end
endmodule
`default_nettype wire
